// ### design/sspg_map.vh
// Summary of operation
// - up raises, down lowers, else hold
// - ramp-up time, default ten seconds
// - separate ramp-down time, default ten seconds
// - start value loaded at first switch-on
// - bit0 chooses start value or saved value
// - auto mode: bit1 clear means instant change
// - manual mode always ramps
// - bit2 enables initial rounding
// - bit3 with bit0 keeps value over power loss
// - bit4 clear: update only with pulses enabled
// - config word resets to 00110
// - output bounded by upper limit
// - output bounded by lower limit
// - increase and decrease default inactive
// - sixteen fixed speed setpoints held
// - direct mode sums selected of four
// - binary mode picks one of sixteen
// - fixed mode one means direct selection
`ifndef SSPG_MAP_VH
`define SSPG_MAP_VH
`define SSPG_REG_CFG        4'h0
`define SSPG_REG_START      4'h1
`define SSPG_REG_UPPER      4'h2
`define SSPG_REG_LOWER      4'h3
`define SSPG_REG_TUP        4'h4
`define SSPG_REG_TDN        4'h5
`define SSPG_REG_CTRL       4'h6
`define SSPG_REG_STAT       4'h7
`define SSPG_REG_FIXMODE    4'h8
`define SSPG_REG_RAMPOUT    4'h9
`define SSPG_REG_FIXOUT     4'ha
`define SSPG_REG_SAVED      4'hb
`define SSPG_FIX_BASE       8'h40
`define SSPG_PAGE_REGS      4'h0
`define SSPG_PAGE_FIX       4'h4
`define SSPG_CFG_RESET      5'h06
`define SSPG_CFG_SAVE       0
`define SSPG_CFG_AUTORAMP   1
`define SSPG_CFG_ROUND      2
`define SSPG_CFG_NVSAVE     3
`define SSPG_CFG_ALWAYS     4
`define SSPG_TIME_RESET_MS  32'h0000_2710
`define SSPG_FIXMODE_DIRECT 2'h1
`define SSPG_ROUND_STEPS    4'h8
`endif

// ### design/sspg_top.v
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "sspg_map.vh"
// ramped setpoint unit plus fixed-speed selector, Avalon-MM register access
module sspg_top #(
    parameter W         = 32,
    parameter CLK_KHZ   = 100000,
    parameter TICK_DIV  = 100
) (
    input  wire          i_ref_clk,
    input  wire          i_resetn,
    input  wire [7:0]    i_avs_address,
    input  wire          i_avs_read,
    input  wire          i_avs_write,
    input  wire [31:0]   i_avs_writedata,
    output reg  [31:0]   o_avs_readdata,
    output reg           o_avs_waitrequest,
    input  wire          i_setpoint_increase_src,
    input  wire          i_setpoint_decrease_src,
    input  wire          i_auto_mode_select,
    input  wire          i_motor_on,
    input  wire          i_pulse_enable,
    input  wire          i_power_fail,
    input  wire [3:0]    i_fixed_select,
    output reg  [W-1:0]  o_ramp_setpoint,
    output reg  [W-1:0]  o_fixed_setpoint
);
    // clock cycles per ramp tick; time registers are in ms, so a step of
    // (upper-lower)/time per ms tick gives full-range travel in the set time
    localparam TICKS_PER_MS = CLK_KHZ / TICK_DIV;

    // block overview
    // two setpoint sources share one clock and one register bus
    // the ramped unit acts like a motor-driven knob
    // the fixed unit picks or sums stored speeds
    //
    // ramped unit inputs
    // increase and decrease come from pins
    // software can raise them too, through the control word
    // pin and software requests are ORed
    // both active at once means hold
    // neither active means hold
    //
    // ramp timebase
    // a tick arrives once per ms of ramp time
    // TICK_DIV shortens the tick for fast benches
    // with TICK_DIV set to CLK_KHZ a tick comes every cycle
    //
    // ramp step
    // step is the limit span divided by the ramp time
    // so full travel takes the programmed time
    // a step below one unit is raised to one
    // a zero time gives the whole span in one step
    // up and down times are separate registers
    //
    // initial rounding
    // while enabled, the first ticks of a move step by one
    // this lets the user nudge the value by tiny amounts
    // the count restarts when the request goes away
    // the count keeps going when up turns straight into down
    //
    // automatic versus manual
    // manual mode always ramps
    // automatic mode ramps only with the auto-ramp bit
    // without it the output jumps to the limit at once
    //
    // pulse dependence
    // with the always bit clear, moves need pulse enable
    // with the bit set, moves ignore pulse enable
    // switch-on loading does not depend on pulses
    //
    // switch-on behaviour
    // a rising motor-on edge is a switch-on
    // a falling edge is a switch-off
    // the first switch-on after reset loads the start value
    // with the save bit, switch-off keeps the value
    // and later switch-ons bring it back
    // without the save bit every switch-on loads start
    //
    // power-fail keeping
    // with save and keep bits, a power-fail level stores
    // the value in a register that reset leaves alone
    // the first switch-on after reset restores it
    // the keep bit must be set again after reset,
    // since the config word resets with it clear
    //
    // limits
    // the output is always clamped to lower..upper
    // both limits reset to zero, so the output sits at zero
    // until software widens them
    // a user who sets lower above upper gets upper for values above it, else lower
    //
    // fixed-speed unit
    // sixteen table words live at word 0x40 upwards
    // mode one sums the first four words per select bit
    // no select bit set gives zero in that mode
    // any other mode picks one word by the 4-bit code
    // the select bits are taken as synchronous levels
    // the output is registered, one cycle after select
    //
    // register bus
    // word addresses, single 32-bit words only
    // a request is taken when waitrequest is high
    // and no answer went out the cycle before
    // waitrequest drops for one cycle to answer
    // read data stand from that edge until the next access
    // a write lands on the taking edge
    // only page 0 and the table page are decoded
    // everything else reads zero and ignores writes
    //
    // register page 0
    // 0 config word, five bits
    // 1 start value
    // 2 upper limit
    // 3 lower limit
    // 4 ramp-up time in ms
    // 5 ramp-down time in ms
    // 6 software up and down requests
    // 7 status: first-on, ramp mode in use, update enable, motor on
    // 8 fixed-speed mode
    // 9 present ramp value
    // 10 present fixed output
    // 11 value saved at switch-off
    //
    // hazards
    // values are signed; limits may be negative
    // a large span with a tiny time can saturate quickly
    // changing limits mid-move clamps on the next cycle
    // the retained register powers up unknown in simulation,
    // and the first cycle marks it empty
    //
    // outputs
    // both setpoint outputs come straight from flip-flops
    // bus outputs are registered as well
    //
    // reset
    // synchronous, active low
    // all outputs but waitrequest read zero during reset
    // waitrequest stays high during reset
    // the first request may come on the first edge after it

    reg  [4:0]          cfg_reg;
    reg  signed [W-1:0] start_reg;
    reg  signed [W-1:0] upper_reg;
    reg  signed [W-1:0] lower_reg;
    reg  [31:0]         tup_reg;
    reg  [31:0]         tdn_reg;
    reg  [1:0]          sw_ctrl_reg;
    reg  [1:0]          fixmode_reg;
    reg  signed [W-1:0] fix_mem [0:15];
    reg  signed [W-1:0] ramp_reg;
    reg  signed [W-1:0] saved_reg;
    reg  signed [W-1:0] nv_reg;
    reg                 nv_valid_reg;
    reg                 motor_on_d_reg;
    reg                 first_on_done_reg;
    reg  [31:0]         tick_cnt_reg;
    reg                 ms_tick_reg;
    reg  [3:0]          round_cnt_reg;
    reg  signed [W-1:0] ramp_next;
    reg  signed [W-1:0] fixed_next;
    reg  signed [W-1:0] step_up;
    reg  signed [W-1:0] step_dn;
    reg  signed [W-1:0] span;
    reg                 bus_done_reg;

    wire inc = i_setpoint_increase_src | sw_ctrl_reg[0];
    wire dec = i_setpoint_decrease_src | sw_ctrl_reg[1];
    wire update_en = cfg_reg[`SSPG_CFG_ALWAYS] | i_pulse_enable;
    wire use_ramp = ~i_auto_mode_select | cfg_reg[`SSPG_CFG_AUTORAMP];
    wire sw_on = i_motor_on & ~motor_on_d_reg;
    wire sw_off = ~i_motor_on & motor_on_d_reg;

    // clamp a value between the lower and upper limit
    function signed [W-1:0] clamp;
        input signed [W-1:0] v;
        input signed [W-1:0] lo;
        input signed [W-1:0] hi;
        begin
            if (v > hi)
                clamp = hi;
            else if (v < lo)
                clamp = lo;
            else
                clamp = v;
        end
    endfunction

    // full-range step per ms, at least one unit
    function signed [W-1:0] step_of;
        input signed [W-1:0] s;
        input [31:0]         t;
        reg   signed [W-1:0] q;
        begin
            q = (t == 32'h0) ? s : s / $signed({1'b0, t[W-2:0]});
            step_of = (q < $signed({{(W-1){1'b0}}, 1'b1})) ?
                      $signed({{(W-1){1'b0}}, 1'b1}) : q;
        end
    endfunction

    // ramp step and initial-rounding scaling
    always @* begin
        span = upper_reg - lower_reg;
        step_up = step_of(span, tup_reg);
        step_dn = step_of(span, tdn_reg);
        if (cfg_reg[`SSPG_CFG_ROUND] && round_cnt_reg < `SSPG_ROUND_STEPS) begin
            step_up = $signed({{(W-1){1'b0}}, 1'b1});
            step_dn = $signed({{(W-1){1'b0}}, 1'b1});
        end
    end

    // next ramped setpoint
    always @* begin
        ramp_next = ramp_reg;
        if (sw_on) begin
            if (!first_on_done_reg && nv_valid_reg && cfg_reg[`SSPG_CFG_SAVE]
                && cfg_reg[`SSPG_CFG_NVSAVE])
                ramp_next = nv_reg;
            else if (cfg_reg[`SSPG_CFG_SAVE] && first_on_done_reg)
                ramp_next = saved_reg;
            else
                ramp_next = start_reg;
        end else if (update_en && (inc ^ dec)) begin
            if (!use_ramp)
                ramp_next = inc ? upper_reg : lower_reg;
            else if (ms_tick_reg)
                ramp_next = inc ? ramp_reg + step_up : ramp_reg - step_dn;
        end
        ramp_next = clamp(ramp_next, lower_reg, upper_reg);
    end

    // fixed-speed selection
    always @* begin
        fixed_next = {W{1'b0}};
        if (fixmode_reg == `SSPG_FIXMODE_DIRECT) begin
            if (i_fixed_select[0]) fixed_next = fixed_next + fix_mem[0];
            if (i_fixed_select[1]) fixed_next = fixed_next + fix_mem[1];
            if (i_fixed_select[2]) fixed_next = fixed_next + fix_mem[2];
            if (i_fixed_select[3]) fixed_next = fixed_next + fix_mem[3];
        end else begin
            fixed_next = fix_mem[i_fixed_select];
        end
    end

    // ms tick timebase
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            tick_cnt_reg <= 32'h0;
            ms_tick_reg  <= 1'b0;
        end else if (tick_cnt_reg >= TICKS_PER_MS - 1) begin
            tick_cnt_reg <= 32'h0;
            ms_tick_reg  <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            ms_tick_reg  <= 1'b0;
        end
    end

    // ramp state, saving, rounding progress
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ramp_reg          <= {W{1'b0}};
            saved_reg         <= {W{1'b0}};
            motor_on_d_reg    <= 1'b0;
            first_on_done_reg <= 1'b0;
            round_cnt_reg     <= 4'h0;
            o_ramp_setpoint   <= {W{1'b0}};
            o_fixed_setpoint  <= {W{1'b0}};
        end else begin
            motor_on_d_reg   <= i_motor_on;
            ramp_reg         <= ramp_next;
            o_ramp_setpoint  <= ramp_next;
            o_fixed_setpoint <= fixed_next;
            if (sw_on)
                first_on_done_reg <= 1'b1;
            if (sw_off && cfg_reg[`SSPG_CFG_SAVE])
                saved_reg <= ramp_reg;
            if (!(inc ^ dec))
                round_cnt_reg <= 4'h0;
            else if (ms_tick_reg && round_cnt_reg < `SSPG_ROUND_STEPS)
                round_cnt_reg <= round_cnt_reg + 4'h1;
        end
    end

    // power-fail store; this register models retained storage and is not reset
    always @(posedge i_ref_clk) begin
        if (i_power_fail && cfg_reg[`SSPG_CFG_SAVE] && cfg_reg[`SSPG_CFG_NVSAVE]) begin
            nv_reg       <= ramp_reg;
            nv_valid_reg <= 1'b1;
        end else if (nv_valid_reg !== 1'b1) begin
            nv_valid_reg <= 1'b0;
            nv_reg       <= {W{1'b0}};
        end
    end

    // Avalon-MM slave: one wait cycle, answer on the second edge
    always @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            cfg_reg           <= `SSPG_CFG_RESET;
            start_reg         <= {W{1'b0}};
            upper_reg         <= {W{1'b0}};
            lower_reg         <= {W{1'b0}};
            tup_reg           <= `SSPG_TIME_RESET_MS;
            tdn_reg           <= `SSPG_TIME_RESET_MS;
            sw_ctrl_reg       <= 2'h0;
            fixmode_reg       <= `SSPG_FIXMODE_DIRECT;
            bus_done_reg      <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0;
        end else begin
            bus_done_reg      <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            if ((i_avs_read || i_avs_write) && !bus_done_reg && o_avs_waitrequest) begin
                bus_done_reg      <= 1'b1;
                o_avs_waitrequest <= 1'b0;
                o_avs_readdata    <= 32'h0;
                if (i_avs_address[7:4] == `SSPG_PAGE_FIX) begin
                    o_avs_readdata <= fix_mem[i_avs_address[3:0]];
                end else if (i_avs_address[7:4] == `SSPG_PAGE_REGS) begin
                    case (i_avs_address[3:0])
                        `SSPG_REG_CFG:     o_avs_readdata <= {27'h0, cfg_reg};
                        `SSPG_REG_START:   o_avs_readdata <= start_reg;
                        `SSPG_REG_UPPER:   o_avs_readdata <= upper_reg;
                        `SSPG_REG_LOWER:   o_avs_readdata <= lower_reg;
                        `SSPG_REG_TUP:     o_avs_readdata <= tup_reg;
                        `SSPG_REG_TDN:     o_avs_readdata <= tdn_reg;
                        `SSPG_REG_CTRL:    o_avs_readdata <= {30'h0, sw_ctrl_reg};
                        `SSPG_REG_STAT:    o_avs_readdata <= {28'h0, first_on_done_reg,
                                                  use_ramp, update_en, i_motor_on};
                        `SSPG_REG_FIXMODE: o_avs_readdata <= {30'h0, fixmode_reg};
                        `SSPG_REG_RAMPOUT: o_avs_readdata <= ramp_reg;
                        `SSPG_REG_FIXOUT:  o_avs_readdata <= o_fixed_setpoint;
                        `SSPG_REG_SAVED:   o_avs_readdata <= saved_reg;
                        default:           o_avs_readdata <= 32'h0;
                    endcase
                end
                if (i_avs_write && i_avs_address[7:4] == `SSPG_PAGE_REGS) begin
                    case (i_avs_address[3:0])
                        `SSPG_REG_CFG:     cfg_reg     <= i_avs_writedata[4:0];
                        `SSPG_REG_START:   start_reg   <= i_avs_writedata;
                        `SSPG_REG_UPPER:   upper_reg   <= i_avs_writedata;
                        `SSPG_REG_LOWER:   lower_reg   <= i_avs_writedata;
                        `SSPG_REG_TUP:     tup_reg     <= i_avs_writedata;
                        `SSPG_REG_TDN:     tdn_reg     <= i_avs_writedata;
                        `SSPG_REG_CTRL:    sw_ctrl_reg <= i_avs_writedata[1:0];
                        `SSPG_REG_FIXMODE: fixmode_reg <= i_avs_writedata[1:0];
                        default:           ;
                    endcase
                end
            end
        end
    end

    // fixed setpoint table writes
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_fix
            always @(posedge i_ref_clk) begin
                if (!i_resetn)
                    fix_mem[g] <= {W{1'b0}};
                else if (i_avs_write && o_avs_waitrequest && !bus_done_reg
                         && i_avs_address == (`SSPG_FIX_BASE | g))
                    fix_mem[g] <= i_avs_writedata;
            end
        end
    endgenerate
endmodule

// ### tb/sspg_sva.sv
`timescale 1ns/1ps
// bus timing and setpoint stability checks at the top ports
module sspg_sva (
    input wire        i_ref_clk,
    input wire        i_resetn,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    input wire        i_setpoint_increase_src,
    input wire        i_setpoint_decrease_src,
    input wire        i_motor_on,
    input wire [3:0]  i_fixed_select,
    input wire [31:0] o_ramp_setpoint,
    input wire [31:0] o_fixed_setpoint
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    wire req  = i_avs_read | i_avs_write;
    wire inc  = i_setpoint_increase_src;
    wire dec  = i_setpoint_decrease_src;
    wire idle = (inc == dec) & ~i_avs_write;
    // request taken, then a single low cycle of waitrequest
    sequence s_take; req && o_avs_waitrequest && $past(o_avs_waitrequest); endsequence
    sequence s_answer; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
    sequence s_up; inc && !dec && !i_avs_write && $stable(i_motor_on); endsequence
    sequence s_dn; dec && !inc && !i_avs_write && $stable(i_motor_on); endsequence
    a_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (1'b0)
        !i_resetn |=> o_avs_waitrequest && o_ramp_setpoint == 0 && o_fixed_setpoint == 0)
        else $error("outputs not quiet after reset");
    a_bus_answer: assert property (s_take |=> s_answer) else $error("bus answer wrong");
    a_answer_cause: assert property (!o_avs_waitrequest |-> $past(req))
        else $error("answer without request");
    a_rdata_stand: assert property (!req && !$past(req) |-> $stable(o_avs_readdata))
        else $error("read data moved while idle");
    a_ramp_hold: assert property (idle && $past(idle) && $stable(i_motor_on)
        && $past(i_motor_on, 2) == i_motor_on |=> $stable(o_ramp_setpoint))
        else $error("ramp moved while idle");
    a_fix_hold: assert property ($stable(i_fixed_select) && !i_avs_write
        && !$past(i_avs_write) |=> $stable(o_fixed_setpoint))
        else $error("fixed output moved");
    a_ramp_rise: assert property (s_up ##1 s_up
        |=> $signed(o_ramp_setpoint) >= $signed($past(o_ramp_setpoint)))
        else $error("ramp fell while raising");
    a_ramp_fall: assert property (s_dn ##1 s_dn
        |=> $signed(o_ramp_setpoint) <= $signed($past(o_ramp_setpoint)))
        else $error("ramp rose while lowering");
endmodule
bind sspg_top sspg_sva sspg_sva_inst (.i_ref_clk, .i_resetn, .i_avs_read, .i_avs_write,
    .o_avs_readdata, .o_avs_waitrequest, .i_setpoint_increase_src, .i_setpoint_decrease_src,
    .i_motor_on, .i_fixed_select, .o_ramp_setpoint, .o_fixed_setpoint);

// ### tb/sspg_ctrl_model.sv
`timescale 1ns/1ps
// superior controller: samples bench commands onto the digital inputs
module sspg_ctrl_model (
    input  wire       i_ref_clk,
    input  wire       i_resetn,
    input  wire       i_cmd_up,
    input  wire       i_cmd_down,
    input  wire [3:0] i_cmd_sel,
    output reg        o_inc,
    output reg        o_dec,
    output reg  [3:0] o_sel
);
    // inputs stay inactive during reset
    always @(posedge i_ref_clk) begin
        o_inc <= i_resetn & i_cmd_up;
        o_dec <= i_resetn & i_cmd_down;
        o_sel <= i_resetn ? i_cmd_sel : 4'h0;
    end
endmodule

// ### tb/sspg_top_test.sv
`timescale 1ns/1ps
`include "sspg_map.vh"
module sspg_top_test;
    reg         clk, rstn, rd, wr, auto, mon, pen, cup, cdn, pf;
    reg  [7:0]  adr;
    reg  [31:0] wdat, rv;
    reg  [3:0]  csel;
    wire        inc, dec, wreq;
    wire [3:0]  sel;
    wire [31:0] rdat, ramp, fix;
    integer     n_mismatch, compares, cyc, s;
    sspg_ctrl_model sspg_ctrl_model_inst (.i_ref_clk(clk), .i_resetn(rstn), .i_cmd_up(cup),
        .i_cmd_down(cdn), .i_cmd_sel(csel), .o_inc(inc), .o_dec(dec), .o_sel(sel));
    sspg_top #(.TICK_DIV(100000)) sspg_top_inst (.i_ref_clk(clk), .i_resetn(rstn),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_setpoint_increase_src(inc),
        .i_setpoint_decrease_src(dec), .i_auto_mode_select(auto), .i_motor_on(mon),
        .i_pulse_enable(pen), .i_power_fail(pf), .i_fixed_select(sel),
        .o_ramp_setpoint(ramp), .o_fixed_setpoint(fix));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task report_and_stop;
        begin
            $display("counts: %0d mismatches, %0d compares", n_mismatch, compares);
            if (n_mismatch == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
                n_mismatch = n_mismatch + 1;
            end
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task acc(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            rd <= !w;
            wr <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk);
            while (wreq !== 1'b0) @(posedge clk);
            rv = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task rchk(input string nm, input [7:0] a, input [31:0] e);
        begin
            acc(1'b0, a, 32'h0);
            chk(nm, e, rv);
        end
    endtask
    // drive up and down commands for n cycles
    task run(input u, input d, input integer n);
        begin
            cup <= u;
            cdn <= d;
            repeat (n) @(posedge clk);
        end
    endtask
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop;
        end
    end
    initial begin
        {rd, wr, auto, mon, pen, cup, cdn, pf} = 8'h00;
        {adr, wdat, csel, cyc, n_mismatch, compares} = 0;
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rchk("cfg", `SSPG_REG_CFG, 32'h6);
        rchk("t_up", `SSPG_REG_TUP, 32'h2710);
        rchk("t_dn", `SSPG_REG_TDN, 32'h2710);
        rchk("start", `SSPG_REG_START, 32'h0);
        rchk("upper", `SSPG_REG_UPPER, 32'h0);
        rchk("lower", `SSPG_REG_LOWER, 32'h0);
        rchk("fixmode", `SSPG_REG_FIXMODE, 32'h1);
        acc(1'b1, 8'h30, 32'h5a);
        rchk("unmapped", 8'h30, 32'h0);
        $display("test reset done");
        for (s = 0; s < 16; s = s + 1) acc(1'b1, `SSPG_FIX_BASE + s, 100 * s + 7);
        for (s = 0; s < 32; s = s + 1) begin
            if (s == 16) acc(1'b1, `SSPG_REG_FIXMODE, 32'h0);
            csel <= s[3:0];
            repeat (4) @(posedge clk);
            if (s < 16)
                chk("fix_dir", s[0]*7 + s[1]*107 + s[2]*207 + s[3]*307, fix);
            else
                chk("fix_bin", 100 * (s - 16) + 7, fix);
        end
        $display("test fixed done");
        acc(1'b1, `SSPG_REG_UPPER, 32'd100);
        acc(1'b1, `SSPG_REG_TUP, 32'd10);
        acc(1'b1, `SSPG_REG_TDN, 32'd10);
        acc(1'b1, `SSPG_REG_CFG, 32'h4);
        pen <= 1'b1;
        mon <= 1'b1;
        run(0, 0, 4);
        chk("ramp_start", 0, ramp);
        run(1, 0, 5);
        chk("ramp_round", 1, ramp > 0 && ramp < 9);
        run(0, 1, 20);
        acc(1'b1, `SSPG_REG_CFG, 32'h0);
        run(1, 0, 3);
        chk("ramp_up_mid", 1, ramp > 8 && ramp < 100);
        run(1, 0, 30);
        chk("ramp_top", 100, ramp);
        run(1, 1, 10);
        chk("ramp_both", 100, ramp);
        run(0, 1, 3);
        chk("ramp_dn_mid", 1, ramp > 0 && ramp < 100);
        run(0, 1, 30);
        chk("ramp_bottom", 0, ramp);
        pen <= 1'b0;
        run(1, 0, 20);
        chk("ramp_nopulse", 0, ramp);
        acc(1'b1, `SSPG_REG_CFG, 32'h10);
        run(1, 0, 30);
        chk("ramp_always", 100, ramp);
        acc(1'b1, `SSPG_REG_CFG, 32'h0);
        auto <= 1'b1;
        pen <= 1'b1;
        run(0, 1, 4);
        chk("ramp_auto", 0, ramp);
        $display("test ramp done");
        acc(1'b1, `SSPG_REG_START, 32'd50);
        for (s = 0; s < 2; s = s + 1) begin
            if (s == 1) acc(1'b1, `SSPG_REG_CFG, 32'h1);
            run(s[0], 1'b0, 4);
            run(0, 0, 4);
            mon <= 1'b0;
            run(0, 0, 4);
            mon <= 1'b1;
            run(0, 0, 6);
            chk("ramp_switch_on", s ? 100 : 50, ramp);
        end
        rchk("saved", `SSPG_REG_SAVED, 32'd100);
        acc(1'b1, `SSPG_REG_CFG, 32'h9);
        pf <= 1'b1;
        mon <= 1'b0;
        run(0, 0, 2);
        pf <= 1'b0;
        rstn <= 1'b0;
        run(0, 0, 2);
        rstn <= 1'b1;
        acc(1'b1, `SSPG_REG_UPPER, 32'd100);
        acc(1'b1, `SSPG_REG_CFG, 32'h9);
        mon <= 1'b1;
        run(0, 0, 4);
        chk("ramp_nv_restore", 100, ramp);
        $display("test switch-on done");
        report_and_stop;
    end
endmodule
